// file: hw/cmos_out_formatter.v
// Parallel single-ended output formatter for a four-channel 11-bit converter.
`timescale 1ns/10ps
`default_nettype none
`include "cmos_out_map.vh"

// The block runs entirely on core_clk. The sample clock arrives as a pin
// and is only ever sampled, never used as a clock, so that the FIFO, the
// formatter and the pin drivers share one timing domain.

// ============================================================
// Sample FIFO
module sample_fifo #(
  parameter WIDTH = 44,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // Clock and reset
  input wire core_clk,
  input wire rstn,
  // Fill side
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // Drain side
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wrPtr_q;
  reg [AW:0] rdPtr_q;
  wire full;
  wire empty;

  // ============================================================
  // Occupancy flags
  // The pointers carry one extra bit, so a full FIFO and an empty one
  // are told apart without a separate occupancy counter.
  assign empty = (wrPtr_q == rdPtr_q);
  assign full = (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]) &&
                (wrPtr_q[AW] != rdPtr_q[AW]);
  assign inReady = ~full;
  assign outValid = ~empty;
  assign outData = mem[rdPtr_q[AW-1:0]];

  // ============================================================
  // Storage
  // The storage has no reset: only entries between the two pointers are
  // ever popped; stale contents reach outData only while outValid is low.
  always @(posedge core_clk) begin
    if (inValid && !full) begin
      mem[wrPtr_q[AW-1:0]] <= inData;
    end
  end

  // ============================================================
  // Pointers
  // A write and a read in the same cycle are both taken; a write into a
  // full FIFO is dropped rather than overwriting the oldest word.
  always @(posedge core_clk) begin
    if (!rstn) begin
      wrPtr_q <= {(AW+1){1'b0}};
      rdPtr_q <= {(AW+1){1'b0}};
    end else begin
      if (inValid && !full) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (outReady && !empty) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
    end
  end
endmodule // sample_fifo

// ============================================================
// Output formatter top
module cmos_out_formatter (
  // Clock and reset
  input wire core_clk,
  input wire rstn,
  // Sample clock from the pin, sampled by core_clk
  input wire sampleClk,
  // Configuration levels from the serial configuration logic
  input wire parallelModeSel,
  input wire [3:0] channel_code_format_select,
  // Converter samples, twos complement, with overdrive flags
  input wire [`CHAN_N*`SAMPLE_W-1:0] rawSample,
  input wire [`CHAN_N-1:0] overPos,
  input wire [`CHAN_N-1:0] overNeg,
  input wire rawValid,
  output reg rawReady_q,
  // Parallel pins
  output reg [`CHAN_N*`SAMPLE_W-1:0] pinData_q,
  output reg forwarded_sample_clock,
  output reg pinOutEnableN_q
);
  reg [2:0] clkSync_q;
  reg [`CHAN_N*`SAMPLE_W-1:0] fmtWord;
  wire clkRise;
  wire clkFall;
  wire fifoInReady;
  wire fifoValid;
  wire [`FIFO_WORD_W-1:0] fifoData;
  reg [`CHAN_N*`SAMPLE_W-1:0] heldWord_q;
  genvar g;


  // ============================================================
  // Sample clock synchroniser
  // Each phase of the sample clock must last longer than one core cycle,
  // or an edge can be missed and a word skipped on the pins.
  // Two flops before use; third stage only feeds edge detection.
  always @(posedge core_clk) begin
    if (!rstn) begin
      clkSync_q <= 3'h0;
    end else begin
      clkSync_q <= {clkSync_q[1:0], sampleClk};
    end
  end
  assign clkRise = clkSync_q[1] & ~clkSync_q[2];
  assign clkFall = ~clkSync_q[1] & clkSync_q[2];


  // ============================================================
  // Sample formatting
  // Positive overdrive wins when both flags are raised together.
  // Format one channel: clamp overdrive, then pick the coding.
  function [`SAMPLE_W-1:0] fmtChan;
    input [`SAMPLE_W-1:0] twos;
    input pos;
    input neg;
    input offBin;
    begin
      if (pos) begin
        fmtChan = offBin ? `POS_FS_OFFBIN : `POS_FS_TWOS;
      end else if (neg) begin
        fmtChan = offBin ? `NEG_FS_OFFBIN : `NEG_FS_TWOS;
      end else if (offBin) begin
        fmtChan = {~twos[`SAMPLE_MSB], twos[`SAMPLE_MSB-1:0]};
      end else begin
        fmtChan = twos;
      end
    end
  endfunction

  // One formatter per channel; each format bit acts on its channel alone.
  generate
    for (g = 0; g < `CHAN_N; g = g + 1) begin : gFmt
      always @* begin
        fmtWord[g*`SAMPLE_W +: `SAMPLE_W] = fmtChan(
          rawSample[g*`SAMPLE_W +: `SAMPLE_W], overPos[g], overNeg[g],
          channel_code_format_select[g]);
      end
    end
  endgenerate


  // ============================================================
  // Fill side
  // Ready is registered to keep the fill path short. It lags the full
  // flag by one cycle, so the FIFO itself refuses a write while full.
  always @(posedge core_clk) begin
    if (!rstn) begin
      rawReady_q <= 1'b0;
    end else begin
      rawReady_q <= fifoInReady;
    end
  end


  // ============================================================
  // Sample FIFO instance
  // It drains one word on each detected fall of the sample clock while it holds one.
  sample_fifo #(
    .WIDTH(`FIFO_WORD_W),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) uFifo (
    .core_clk(core_clk),
    .rstn(rstn),
    .inValid(rawValid & rawReady_q),
    .inReady(fifoInReady),
    .inData(fmtWord),
    .outValid(fifoValid),
    .outReady(clkFall),
    .outData(fifoData)
  );


  // ============================================================
  // Pin drivers
  // In double-rate mode the pins are released but the words keep moving
  // inside, so a switch back to parallel mode shows current data at once
  // instead of a stale backlog.
  // Data changes on the falling sample edge so the rising edge of the
  // forwarded clock sits mid-word; an empty FIFO repeats the last word.
  always @(posedge core_clk) begin
    if (!rstn) begin
      heldWord_q <= {(`CHAN_N*`SAMPLE_W){1'b0}};
      pinData_q <= {(`CHAN_N*`SAMPLE_W){1'b0}};
      forwarded_sample_clock <= 1'b0;
      pinOutEnableN_q <= 1'b1;
    end else begin
      pinOutEnableN_q <= ~parallelModeSel;
      if (clkRise) begin
        forwarded_sample_clock <= 1'b1;
      end else if (clkFall) begin
        forwarded_sample_clock <= 1'b0;
        if (fifoValid) begin
          heldWord_q <= fifoData;
          pinData_q <= fifoData;
        end else begin
          pinData_q <= heldWord_q;
        end
      end
    end
  end
endmodule // cmos_out_formatter
`default_nettype wire

// file: pkg/cmos_out_map.vh
// Constants for the parallel sample output formatter.
`ifndef CMOS_OUT_MAP_VH
`define CMOS_OUT_MAP_VH
`define SAMPLE_W 11
`define CHAN_N 4
`define SAMPLE_MSB 10
`define POS_FS_OFFBIN 11'h7ff
`define POS_FS_TWOS 11'h3ff
`define NEG_FS_OFFBIN 11'h000
`define NEG_FS_TWOS 11'h400
`define FMT_RESET 4'h0
`define FIFO_DEPTH 32
`define FIFO_AW 5
`define FIFO_WORD_W 44
`endif

// file: sim/pin_catcher.sv
// Receiver model that latches the parallel pins.
`timescale 1ns/10ps
`default_nettype none
module pin_catcher (input wire logic c, input wire logic [43:0] d,
  output logic [43:0] q);
  always @(posedge c) q <= d;
endmodule // pin_catcher
`default_nettype wire

// file: sim/fmt_props.sv
// Checker for the formatter pins.
`timescale 1ns/10ps
`default_nettype none
module fmt_props (
  input wire logic core_clk, rstn, sampleClk, parallelModeSel, rawValid,
  input wire logic rawReady_q, forwarded_sample_clock, pinOutEnableN_q,
  input wire logic [43:0] pinData_q);
  wire fc = forwarded_sample_clock;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  property p_oe; 1 |=> pinOutEnableN_q == !$past(parallelModeSel); endproperty
  a_oe: assert property (p_oe) else $error("oe");
  property p_up; $changed(pinData_q) |-> $fell(fc); endproperty
  a_up: assert property (p_up) else $error("up");
  property p_hd; fc |-> $stable(pinData_q); endproperty
  a_hd: assert property (p_hd) else $error("hd");
  property p_fl; $fell(sampleClk) |-> ##[1:3] $fell(fc); endproperty
  a_fl: assert property (p_fl) else $error("fl");
  property p_rs; $rose(sampleClk) |-> ##[1:3] $rose(fc); endproperty
  a_rs: assert property (p_rs) else $error("rs");
  property p_rd; $rose(fc) |-> $stable(pinData_q); endproperty
  a_rd: assert property (p_rd) else $error("rd");
  cover property (rawValid && rawReady_q);
  cover property (rawValid && !rawReady_q);
  cover property ($fell(fc) && !pinOutEnableN_q);
endmodule // fmt_props
bind cmos_out_formatter fmt_props u_props(.*);
`default_nettype wire

// file: sim/adc_cmos_output_formatter_bench.sv
// Formatter bench with a queue model.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) nTests++; if ((a) !== (b)) begin miscompares++; \
  $display("BAD %0t %h %h", $time, a, b); end
module adc_cmos_output_formatter_bench;
  logic core_clk = 0, rstn = 0, sampleClk = 0, parallelModeSel = 0;
  logic rawValid = 0, rawReady_q, forwarded_sample_clock, pinOutEnableN_q;
  logic [3:0] channel_code_format_select = 0, overPos = 0, overNeg = 0;
  logic [43:0] rawSample = 0, pinData_q, word, cur = 0, w, q[$];
  logic v = 0, f = 0, r = 0, m = 0;
  integer miscompares = 0, nTests = 0, seed = 32'h9cae, i, g, n;
  cmos_out_formatter DUT(.*);
  pin_catcher RX(.c(forwarded_sample_clock), .d(pinData_q), .q(word));
  initial forever #2 core_clk = ~core_clk;
  initial forever #62.5 sampleClk = ~sampleClk;
  initial begin #99999; miscompares++; end_of_test; end
  // The FIFO pops its old head before a write on the same edge lands.
  always @(posedge core_clk) begin
    n = q.size();
    if (r) begin
      `CHK(rawReady_q, n < 32)
      `CHK(pinOutEnableN_q, !m)
    end
    r = rstn;
    m = parallelModeSel;
    if (f && !forwarded_sample_clock && n > 0) cur = q.pop_front();
    if (v && n < 32) q.push_back(w);
    v = rawValid && rawReady_q;
    w = rawSample;
    f = forwarded_sample_clock;
    for (g = 0; g < 4; g++) begin
      if (overPos[g]) w[11*g+:11] = 11'h3ff;
      else if (overNeg[g]) w[11*g+:11] = 11'h400;
      w[11*g+10] ^= channel_code_format_select[g];
    end
  end
  always @(posedge forwarded_sample_clock) #1 begin
    `CHK(word, cur)
  end
  initial begin
    repeat (5) @(negedge core_clk);
    rstn = 1;
    for (i = 0; i < 4200; i++) begin
      @(negedge core_clk);
      parallelModeSel = i > 9;
      rawValid = i < 300 || i < 3000 && $random(seed) % 40 == 0;
      rawSample = 44'({$random(seed), $random(seed)});
      {overPos, overNeg} = 8'($random(seed) & $random(seed));
      channel_code_format_select = 4'(i >> 8);
    end
    $display("stream test done");
    end_of_test;
  end
  task automatic end_of_test;
    $display("%0d compares, %0d bad", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
endmodule // adc_cmos_output_formatter_bench
`default_nettype wire
